//--- src/wlr_defs.svh
`ifndef WLR_DEFS_SVH
`define WLR_DEFS_SVH

// register map
`define WLR_ADDR_W            8
`define WLR_DATA_W            8
`define WLR_ADDR_LOCK         8'h10
`define WLR_ADDR_SUPPLY_STAT  8'h02
`define WLR_ADDR_DEV_STAT2    8'h03
`define WLR_LOCK_RESET        8'h00

// lock register fields
`define WLR_BIT_INIT_DONE     7
`define WLR_BIT_REPORT_DIS    3
`define WLR_KEY_MSB           1
`define WLR_KEY_LSB           0
`define WLR_KEY_CLEAR_MASK    8'hFC
`define WLR_KEY_STEP1         2'h0
`define WLR_KEY_STEP2         2'h3
`define WLR_KEY_STEP3         2'h2

// status field placement
`define WLR_BIT_RW_ERR        5
`define WLR_BIT_SUPPLY_ERR    0

// error detection over user writable registers
`define WLR_USER_BYTES        16
`define WLR_USER_BITS         128
`define WLR_CODE_BYTES        17

// supply recovery timing
`define WLR_CLK_PERIOD_NS     8
`define WLR_SUP_RCV_US        100
`define WLR_SUP_RCV_CYCLES    ((`WLR_SUP_RCV_US * 1000) / `WLR_CLK_PERIOD_NS)
`define WLR_TIMER_W           16
`define WLR_TIMER_ZERO        16'h0000
`define WLR_TIMER_ONE         16'h0001

`endif

//--- src/wlr_pkg.sv
`include "wlr_defs.svh"

package wlr_pkg;

  // host request from the serial front end
  typedef struct packed {
    logic                   write;
    logic [`WLR_ADDR_W-1:0] addr;
    logic [`WLR_DATA_W-1:0] wdata;
  } wlr_req_t;

  // answer to the serial front end
  typedef struct packed {
    logic                   mute;
    logic                   nack;
    logic                   err_code;
    logic [`WLR_DATA_W-1:0] data;
  } wlr_resp_t;

  // soft reset key tracking
  typedef enum logic [1:0] {
    WLR_KEY_IDLE,
    WLR_KEY_GOT1,
    WLR_KEY_GOT2
  } wlr_key_step_t;

endpackage : wlr_pkg

//--- src/wlr_supply_mon.sv
`timescale 1ns/100ps
`include "wlr_defs.svh"

module wlr_supply_mon
  import wlr_pkg::*;
#(
  parameter int unsigned RCV_CYCLES = `WLR_SUP_RCV_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // supply fault pin
  input  wire logic fault_pin,
  // mode and clear events
  input  wire logic i2c_mode,
  input  wire logic report_dis,
  input  wire logic clr_read,
  input  wire logic clr_tx,
  input  wire logic resp_taken,
  // state
  output logic      busy_r,
  output logic      err_r,
  output logic      code_pend_r
);

  localparam logic [`WLR_TIMER_W-1:0] RCV_LOAD = RCV_CYCLES[`WLR_TIMER_W-1:0];

  logic                    sync1_r;
  logic                    sync2_r;
  logic [`WLR_TIMER_W-1:0] timer_r;
  logic [`WLR_TIMER_W-1:0] timer_nxt;
  logic                    busy_nxt;
  logic                    err_nxt;
  logic                    pend_nxt;
  wire                     spi_mode  = !i2c_mode;
  wire                     timer_zero = (timer_r == `WLR_TIMER_ZERO);
  wire                     expiring   = (timer_r == `WLR_TIMER_ONE) && !sync2_r;
  wire                     clr_ok;

  // shared timer reloaded while the synchronised fault pin is high
  assign timer_nxt = sync2_r ? RCV_LOAD :
                     timer_zero ? timer_r : timer_r - `WLR_TIMER_ONE;
  assign busy_nxt  = (timer_nxt != `WLR_TIMER_ZERO);

  // clear paths per mode, only once the timer has run out
  assign clr_ok = timer_zero && (
                    (spi_mode && !report_dis && (clr_read || clr_tx)) ||
                    (spi_mode && report_dis) ||
                    (i2c_mode && clr_read));
  assign err_nxt  = sync2_r || (err_r && !clr_ok);

  // one error code response after expiry, in SPI mode with reporting enabled only
  assign pend_nxt = (expiring && err_r && spi_mode && !report_dis) ||
                    (code_pend_r && !resp_taken);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_r     <= 1'b0;
      sync2_r     <= 1'b0;
      timer_r     <= `WLR_TIMER_ZERO;
      busy_r      <= 1'b0;
      err_r       <= 1'b0;
      code_pend_r <= 1'b0;
    end else begin
      sync1_r     <= fault_pin;
      sync2_r     <= sync1_r;
      timer_r     <= timer_nxt;
      busy_r      <= busy_nxt;
      err_r       <= err_nxt;
      code_pend_r <= pend_nxt;
    end
  end

endmodule : wlr_supply_mon

//--- src/wlr_lock_ctrl.sv
`timescale 1ns/100ps
`include "wlr_defs.svh"

module wlr_lock_ctrl
  import wlr_pkg::*;
#(
  parameter int unsigned SUP_RCV_CYCLES = `WLR_SUP_RCV_CYCLES
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // host request from the serial front end
  input  wire logic                       req_valid,
  input  wire wlr_req_t                   req,
  input  wire logic                       i2c_mode,
  input  wire logic [`WLR_DATA_W-1:0]     ext_rdata,
  input  wire logic                       status_tx_err,
  // user writable register image
  input  wire logic [`WLR_USER_BITS-1:0]  user_regs,
  // self-test and supply
  input  wire logic                       self_test_req,
  input  wire logic                       supply_fault_pin,
  // answer to the front end
  output logic                            resp_valid_r,
  output wlr_resp_t                       resp_r,
  // write strobe to the other registers
  output logic                            ext_wr_en_r,
  output wlr_req_t                        ext_wr_r,
  // lock state and effects
  output logic [`WLR_DATA_W-1:0]          write_lock_reset_reg,
  output logic                            init_done_lock,
  output logic                            supply_error_report_disable,
  output logic                            soft_reset_r,
  output logic                            self_test_run_r,
  output logic                            rw_err_r,
  output logic                            supply_err,
  output logic                            supply_busy
);

  logic [`WLR_DATA_W-1:0]  lock_r;
  logic [`WLR_DATA_W-1:0]  lock_nxt;
  wlr_key_step_t           step_r;
  wlr_key_step_t           step_nxt;
  logic [`WLR_DATA_W-1:0]  code_snap_r;
  logic                    code_armed_r;
  logic                    rw_err_nxt;
  wlr_resp_t               resp_nxt;
  logic                    sup_err_w;
  logic                    sup_busy_w;
  logic                    sup_pend_w;

  // request decode
  wire                     lock_hit  = req_valid && (req.addr == `WLR_ADDR_LOCK);
  wire                     lock_wr   = lock_hit && req.write;
  wire                     lock_rd   = lock_hit && !req.write;
  wire                     other_wr  = req_valid && req.write && !lock_hit;
  wire                     other_acc = req_valid && !lock_hit;
  wire                     locked    = lock_r[`WLR_BIT_INIT_DONE];
  wire [1:0]               key_w     = req.wdata[`WLR_KEY_MSB:`WLR_KEY_LSB];
  wire                     sup_rd    = req_valid && !req.write &&
                                       (req.addr == `WLR_ADDR_SUPPLY_STAT);
  wire                     stat2_rd  = req_valid && !req.write &&
                                       (req.addr == `WLR_ADDR_DEV_STAT2);

  // key sequence tracking
  wire                     key_s1    = (key_w == `WLR_KEY_STEP1);
  wire                     key_s2    = (key_w == `WLR_KEY_STEP2);
  wire                     key_s3    = (key_w == `WLR_KEY_STEP3);
  wire                     key_fire  = lock_wr && (step_r == WLR_KEY_GOT2) && key_s3;

  always_comb begin
    step_nxt = step_r;
    if (lock_wr) begin
      unique case (step_r)
        WLR_KEY_GOT1: begin
          step_nxt = key_s2 ? WLR_KEY_GOT2 :
                     key_s1 ? WLR_KEY_GOT1 : WLR_KEY_IDLE;
        end
        WLR_KEY_GOT2: begin
          step_nxt = key_s3 ? WLR_KEY_IDLE :
                     key_s1 ? WLR_KEY_GOT1 : WLR_KEY_IDLE;
        end
        WLR_KEY_IDLE: begin
          step_nxt = key_s1 ? WLR_KEY_GOT1 : WLR_KEY_IDLE;
        end
        default: begin
          step_nxt = WLR_KEY_IDLE;
        end
      endcase
    end else if (lock_rd || other_acc) begin
      step_nxt = WLR_KEY_IDLE;
    end
  end

  // lock register update
  wire [`WLR_DATA_W-1:0]   wr_open   = {lock_r[`WLR_BIT_INIT_DONE] |
                                        req.wdata[`WLR_BIT_INIT_DONE],
                                        req.wdata[`WLR_BIT_INIT_DONE-1:0]};
  wire [`WLR_DATA_W-1:0]   wr_locked = {lock_r[`WLR_DATA_W-1:`WLR_KEY_MSB+1],
                                        key_w};

  assign lock_nxt = lock_wr ? (locked ? wr_locked : wr_open) :
                    lock_rd ? (lock_r & `WLR_KEY_CLEAR_MASK) :
                    lock_r;

  // write strobe for the rest of the map
  wire                     ext_wr_ok = other_wr && !locked;

  // error detection code, key bits masked
  wire [`WLR_CODE_BYTES*`WLR_DATA_W-1:0] code_src =
    {user_regs, lock_r & `WLR_KEY_CLEAR_MASK};
  logic [`WLR_DATA_W-1:0]  code_now;

  genvar gi;
  generate
    for (gi = 0; gi < `WLR_DATA_W; gi++) begin : g_code
      logic [`WLR_CODE_BYTES-1:0] col;
      genvar gj;
      for (gj = 0; gj < `WLR_CODE_BYTES; gj++) begin : g_col
        assign col[gj] = code_src[gj*`WLR_DATA_W + ((gi + gj) % `WLR_DATA_W)];
      end
      assign code_now[gi] = ^col;
    end
  endgenerate

  wire                     code_bad  = code_armed_r && (code_now != code_snap_r);
  assign rw_err_nxt = code_bad || (rw_err_r && !stat2_rd);

  // supply monitor
  wlr_supply_mon #(
    .RCV_CYCLES (SUP_RCV_CYCLES)
  ) u_supply (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .fault_pin   (supply_fault_pin),
    .i2c_mode    (i2c_mode),
    .report_dis  (lock_r[`WLR_BIT_REPORT_DIS]),
    .clr_read    (sup_rd),
    .clr_tx      (status_tx_err || (req_valid && sup_pend_w)),
    .resp_taken  (req_valid && !sup_busy_w),
    .busy_r      (sup_busy_w),
    .err_r       (sup_err_w),
    .code_pend_r (sup_pend_w)
  );

  // read data selection
  wire [`WLR_DATA_W-1:0]   rd_stat2  = ext_rdata |
                                       ({{(`WLR_DATA_W-1){1'b0}}, rw_err_r} << `WLR_BIT_RW_ERR);
  wire [`WLR_DATA_W-1:0]   rd_sup    = ext_rdata |
                                       ({{(`WLR_DATA_W-1){1'b0}}, sup_err_w} << `WLR_BIT_SUPPLY_ERR);
  wire [`WLR_DATA_W-1:0]   rd_data   = lock_rd  ? (lock_r & `WLR_KEY_CLEAR_MASK) :
                                       stat2_rd ? rd_stat2 :
                                       sup_rd   ? rd_sup : ext_rdata;

  // answer build
  always_comb begin
    resp_nxt          = '0;
    resp_nxt.mute     = sup_busy_w || key_fire;
    resp_nxt.nack     = key_fire && i2c_mode;
    resp_nxt.err_code = sup_pend_w && !sup_busy_w;
    resp_nxt.data     = lock_wr ? lock_nxt : rd_data;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_r       <= `WLR_LOCK_RESET;
      step_r       <= WLR_KEY_IDLE;
      resp_valid_r <= 1'b0;
      resp_r       <= '0;
      ext_wr_en_r  <= 1'b0;
      ext_wr_r     <= '0;
      soft_reset_r <= 1'b0;
    end else begin
      lock_r       <= lock_nxt;
      step_r       <= step_nxt;
      resp_valid_r <= req_valid;
      resp_r       <= resp_nxt;
      ext_wr_en_r  <= ext_wr_ok;
      ext_wr_r     <= req;
      soft_reset_r <= key_fire;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      code_armed_r    <= 1'b0;
      code_snap_r     <= '0;
      rw_err_r        <= 1'b0;
      self_test_run_r <= 1'b0;
    end else begin
      code_armed_r    <= locked;
      if (locked && !code_armed_r) begin
        code_snap_r <= code_now;
      end
      rw_err_r        <= rw_err_nxt;
      self_test_run_r <= self_test_req && !locked;
    end
  end

  // state seen outside
  assign write_lock_reset_reg        = lock_r;
  assign init_done_lock              = lock_r[`WLR_BIT_INIT_DONE];
  assign supply_error_report_disable = lock_r[`WLR_BIT_REPORT_DIS];
  assign supply_err                  = sup_err_w;
  assign supply_busy                 = sup_busy_w;

endmodule : wlr_lock_ctrl

//--- verif/wlr_props.sv
`timescale 1ns/100ps
`include "wlr_defs.svh"

module wlr_props
  import wlr_pkg::*;
#(
  parameter int unsigned SUP_RCV_CYCLES = 20
) (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  // requests
  input wire logic                   req_valid,
  input wire wlr_req_t               req,
  input wire logic                   i2c_mode,
  // answers and state
  input wire logic                   resp_valid_r,
  input wire wlr_resp_t              resp_r,
  input wire logic                   ext_wr_en_r,
  input wire logic [`WLR_DATA_W-1:0] write_lock_reset_reg,
  input wire logic                   init_done_lock,
  input wire logic                   soft_reset_r,
  input wire logic                   self_test_run_r,
  input wire logic                   supply_busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  wire lock_wr = req_valid && req.write && req.addr == `WLR_ADDR_LOCK;
  wire lock_rd = req_valid && !req.write && req.addr == `WLR_ADDR_LOCK;

  a_answer_next: assert property (req_valid |=> resp_valid_r)
    else $error("no answer after request");
  a_init_sticky: assert property (init_done_lock |=> init_done_lock)
    else $error("lock bit dropped");
  a_locked_no_write: assert property (init_done_lock && req_valid |=> !ext_wr_en_r)
    else $error("write passed while locked");
  a_keys_only: assert property (lock_wr && init_done_lock |=>
    write_lock_reset_reg[7:2] == $past(write_lock_reset_reg[7:2]))
    else $error("locked bits changed");
  a_test_blocked: assert property (init_done_lock |=> !self_test_run_r)
    else $error("self-test runs while locked");
  a_reset_silent: assert property (soft_reset_r |-> resp_valid_r && resp_r.mute
    && resp_r.nack == $past(i2c_mode))
    else $error("answer given on reset");
  a_reset_cause: assert property (soft_reset_r |-> $past(req_valid)
    && $past(req.write) && $past(req.wdata[1:0]) == 2'h2)
    else $error("reset without third key");
  a_busy_mute: assert property (supply_busy && req_valid ##1 supply_busy |-> resp_r.mute)
    else $error("answer while supply busy");
  a_read_keys: assert property (lock_rd |=> resp_r.data[1:0] == 2'h0
    && write_lock_reset_reg[1:0] == 2'h0)
    else $error("key bits not cleared by read");
  a_write_echo: assert property (lock_wr && !init_done_lock |=>
    resp_r.mute || resp_r.data == $past(req.wdata))
    else $error("write answer not new value");
endmodule : wlr_props

//--- verif/wlr_host.sv
`timescale 1ns/100ps

module wlr_host
  import wlr_pkg::*;
(
  // clock
  input wire logic        core_clk,
  // request side
  output logic            req_valid,
  output wlr_req_t        req,
  output logic [7:0]      ext_rdata
);
  initial begin
    req_valid = 1'b0;
    req = '0;
    ext_rdata = 8'h00;
  end

  // one request pulse; the answer stands at the falling edge after it is taken
  task automatic xfer(input logic w, input logic [7:0] a, d, x);
    @(negedge core_clk);
    req_valid <= 1'b1;
    req <= '{w, a, d};
    ext_rdata <= x;
    @(negedge core_clk);
    req_valid <= 1'b0;
    ext_rdata <= ~x;
  endtask : xfer
endmodule : wlr_host

//--- verif/tb_top.sv
`timescale 1ns/100ps
`include "wlr_defs.svh"

module tb_top
  import wlr_pkg::*;
;
  localparam int unsigned RCV = 20;
  logic core_clk = 0, rst_n = 0, i2c_mode = 0, tx_err = 0, st_req = 0, pin = 0;
  logic req_valid, resp_valid_r, ext_wr_en_r, init_done_lock, dis_o, soft_reset_r;
  logic self_test_run_r, rw_err_r, supply_err, supply_busy;
  logic [7:0] ext_rdata, lock_o, xtra = 8'h00, lock_m = 8'h00;
  logic [127:0] user_regs = '0;
  wlr_req_t req, ext_wr_r;
  wlr_resp_t resp_r;
  int n_mismatch = 0, check_count = 0, seed = 33436, step = 0;
  bit mute_e = 0;

  always #4 core_clk = ~core_clk;

  wlr_host host (.core_clk(core_clk), .req_valid(req_valid), .req(req), .ext_rdata(ext_rdata));
  wlr_lock_ctrl #(.SUP_RCV_CYCLES(RCV)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .i2c_mode(i2c_mode), .ext_rdata(ext_rdata),
    .status_tx_err(tx_err), .user_regs(user_regs), .self_test_req(st_req),
    .supply_fault_pin(pin), .resp_valid_r(resp_valid_r), .resp_r(resp_r),
    .ext_wr_en_r(ext_wr_en_r), .ext_wr_r(ext_wr_r), .write_lock_reset_reg(lock_o),
    .init_done_lock(init_done_lock), .supply_error_report_disable(dis_o),
    .soft_reset_r(soft_reset_r), .self_test_run_r(self_test_run_r), .rw_err_r(rw_err_r),
    .supply_err(supply_err), .supply_busy(supply_busy));

  task chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task rst;
    @(negedge core_clk);
    rst_n = 0;
    repeat (16) @(negedge core_clk);
    rst_n = 1;
    lock_m = 8'h00;
    step = 0;
  endtask : rst

  task op(input bit w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic [7:0] e;
    bit r;
    x = $random(seed);
    e = x | xtra;
    r = 0;
    host.xfer(w, a, d, x);
    if (a == `WLR_ADDR_LOCK && w) begin
      lock_m = lock_m[7] ? {lock_m[7:2], d[1:0]} : d;
      r = step == 2 && d[1:0] == 2'h2;
      step = r ? 0 : (step == 1 && d[1:0] == 2'h3) ? 2 : (d[1:0] == 2'h0) ? 1 : 0;
      e = lock_m;
    end else begin
      step = 0;
      if (a == `WLR_ADDR_LOCK) begin
        lock_m[1:0] = 2'h0;
        e = lock_m;
      end
    end
    chk(resp_valid_r === 1'b1, "no answer");
    chk(soft_reset_r === r, "soft reset");
    chk(lock_o === lock_m, "lock value");
    chk(ext_wr_en_r === (w && a != `WLR_ADDR_LOCK && !lock_m[7]), "write strobe");
    chk(resp_r.mute === (r || mute_e), "mute state");
    chk(resp_r.nack === (r && i2c_mode), "acknowledge");
    chk(ext_wr_r === {w, a, d} && dis_o === lock_m[3], "write copy");
    if (!(r || mute_e) && (a == `WLR_ADDR_LOCK || !w)) chk(resp_r.data === e, "read data");
    if (r) rst;
  endtask : op

  task kw(input logic [1:0] k);
    logic [7:0] v;
    v = $random(seed);
    op(1, `WLR_ADDR_LOCK, {1'b0, v[6:2], k});
  endtask : kw

  task sup(input logic i2c, input logic dis);
    i2c_mode = i2c;
    op(1, `WLR_ADDR_LOCK, {4'h0, dis, 3'h0});
    pin = 1;
    repeat (4) @(negedge core_clk);
    pin = 0;
    mute_e = 1;
    op(0, 8'h20, 8'h00);
    mute_e = 0;
    repeat (RCV + 6) @(negedge core_clk);
  endtask : sup

  initial begin
    logic [7:0] a;
    rst;
    chk(lock_o === 8'h00 && init_done_lock === 1'b0 && resp_valid_r === 1'b0, "reset value");
    repeat (40) begin
      a = $random(seed);
      op($random(seed), a[0] ? `WLR_ADDR_LOCK : a, $random(seed) & 8'h7F);
    end
    kw(0); kw(3); op(0, `WLR_ADDR_LOCK, 8'h00); kw(2);
    kw(0); kw(0); kw(3); kw(2);
    sup(0, 0);
    chk(supply_err === 1'b1, "error lost early");
    op(0, 8'h20, 8'h00);
    chk(resp_r.err_code === 1'b1 && supply_err === 1'b0, "no error code");
    op(0, 8'h20, 8'h00);
    chk(resp_r.err_code === 1'b0, "error code twice");
    sup(0, 0);
    tx_err = 1;
    @(negedge core_clk);
    tx_err = 0;
    @(negedge core_clk);
    chk(supply_err === 1'b0, "tx did not clear");
    sup(0, 1);
    chk(supply_err === 1'b0, "no auto clear");
    sup(1, 0);
    chk(supply_err === 1'b1, "error lost early");
    xtra = 8'h01;
    op(0, `WLR_ADDR_SUPPLY_STAT, 8'h00);
    xtra = 8'h00;
    chk(supply_err === 1'b0, "read did not clear");
    kw(0); kw(3); kw(2);
    i2c_mode = 0;
    st_req = 1;
    repeat (2) @(negedge core_clk);
    chk(self_test_run_r === 1'b1, "self-test idle");
    op(1, `WLR_ADDR_LOCK, 8'h84);
    @(negedge core_clk);
    chk(self_test_run_r === 1'b0, "self-test runs");
    repeat (10) op($random(seed), $random(seed) | 8'h20, $random(seed));
    op(1, `WLR_ADDR_LOCK, 8'h7F);
    repeat (3) @(negedge core_clk);
    chk(rw_err_r === 1'b0, "key bits in code");
    user_regs[7:0] = 8'($random(seed)) | 8'h01;
    repeat (4) @(negedge core_clk);
    chk(rw_err_r === 1'b1, "change not caught");
    xtra = 8'h20;
    op(0, `WLR_ADDR_DEV_STAT2, 8'h00);
    xtra = 8'h00;
    kw(0); kw(3); kw(2);
    wrap_up;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    wrap_up;
  end
endmodule : tb_top

bind wlr_lock_ctrl wlr_props #(.SUP_RCV_CYCLES(SUP_RCV_CYCLES)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
  .i2c_mode(i2c_mode), .resp_valid_r(resp_valid_r), .resp_r(resp_r),
  .ext_wr_en_r(ext_wr_en_r), .write_lock_reset_reg(write_lock_reset_reg),
  .init_done_lock(init_done_lock), .soft_reset_r(soft_reset_r),
  .self_test_run_r(self_test_run_r), .supply_busy(supply_busy));
